// ==== verilog/rtc_lf_cfg.svh ====
`ifndef RTC_LF_CFG_SVH
`define RTC_LF_CFG_SVH

// Register indices; the byte address on the bus is four times the index.
`define IDX_LF_CFG          12'h02f
`define IDX_HF_TUNE         12'h04e
`define IDX_CAL_CNT         12'h050
`define IDX_CAL_CTRL        12'h052
`define IDX_PLL_CFG         12'h04b
`define IDX_FLAG_CTRL       12'h030
`define IDX_MODE_CTRL       12'h031
`define IDX_TRIG            12'h034
`define IDX_TICK_CNT        12'h038
`define IDX_TWO_SEC_CNT     12'h03a
`define IDX_DAY_CNT         12'h03c
`define REG_ADDR(idx)       ((idx) << 2)

// Low-frequency oscillator configuration fields.
`define LF_PIN_BIT          7
`define LF_SRC_BIT          2
`define LF_RC_PON_BIT       1
`define LF_XT_PON_BIT       0

// High-frequency crystal tune: writable bit mask and reset value.
`define HF_TUNE_MASK        8'h73
`define HF_TUNE_RST         8'h31

// Calibration control fields.
`define CAL_EN_BIT          0
`define CAL_HALT_BIT        1

// PLL parameter field.
`define PLL_MSB             6
`define PLL_RST             7'h4a

// Flag and control fields.
`define FLG_MATCH_BIT       7
`define FLG_PERIOD_BIT      6
`define FLG_MATCH_CLR_BIT   5
`define FLG_PERIOD_CLR_BIT  4

// Mode control fields.
`define MODE_DAY_LOAD_BIT   7
`define MODE_SUB_LOAD_BIT   6
`define MODE_MATCH_EN_BIT   5
`define MODE_PERIOD_EN_BIT  4
`define MODE_IGN_LSB_BIT    3
`define MODE_SEL_MSB        2
`define MODE_SEL_RST        3'h2

// Counter geometry: 4096 ticks make the shortest period of 0.125 s.
`define PERIOD_BASE_TICKS   32'h0000_1000
`define TWO_SEC_PER_DAY     16'ha8c0
`define DAY_WIDTH           14

`endif

// ==== verilog/rtc_lf_pkg.sv ====
package rtc_lf_pkg;

   typedef struct packed {
      logic source_select;
      logic rc_power;
      logic crystal_power;
   } osc_ctrl_t;

   typedef enum logic [1:0] {
      CAL_IDLE,
      CAL_ARM,
      CAL_RUN
   } cal_state_t;

endpackage : rtc_lf_pkg

// ==== verilog/rtc_lowfreq_clock_control.sv ====
`timescale 1ns/1ps
`include "rtc_lf_cfg.svh"

module rtc_lowfreq_clock_control #(
   parameter int CAL_PERIODS = 5,
   parameter int CAL_WIDTH   = 14
) (
   // Clock and reset
   input  wire logic                  i_clk,
   input  wire logic                  i_rstn,
   // APB slave
   input  wire logic                  i_psel,
   input  wire logic                  i_penable,
   input  wire logic                  i_pwrite,
   input  wire logic [11:0]           i_paddr,
   input  wire logic [31:0]           i_pwdata,
   output logic      [31:0]           o_prdata,
   output logic                       o_pready,
   output logic                       o_pslverr,
   // Low-frequency clock pin
   input  wire logic                  i_lowfreq_clock,
   // Analog and clock controls
   output rtc_lf_pkg::osc_ctrl_t      o_osc_ctrl,
   output logic      [7:0]            o_hf_tune,
   output logic      [`PLL_MSB:0]     o_pll_param,
   // Event flags, held until cleared
   output logic                       o_match_flag,
   output logic                       o_period_flag
);
   import rtc_lf_pkg::*;

   if (CAL_PERIODS < 2 || CAL_PERIODS > 15 || CAL_WIDTH < 4 || CAL_WIDTH > 16) begin : g_bad
      $error("rtc_lowfreq_clock_control: unsupported calibration parameters");
   end

   localparam int EW = 4;

   osc_ctrl_t              osc_reg;
   logic [7:0]             hf_tune_reg;
   logic [`PLL_MSB:0]      pll_reg;
   logic                   cal_en_reg;
   cal_state_t             cal_state_reg;
   logic [CAL_WIDTH-1:0]   cal_cycles_reg;
   logic [CAL_WIDTH-1:0]   cal_count_reg;
   logic [EW-1:0]          cal_edges_reg;
   logic                   match_en_reg;
   logic                   period_en_reg;
   logic                   ignore_lsb_reg;
   logic [2:0]             period_sel_reg;
   logic [31:0]            trig_reg;
   logic [15:0]            tick_reg;
   logic [15:0]            two_sec_reg;
   logic [`DAY_WIDTH-1:0]  day_reg;
   logic                   match_flag_reg;
   logic                   period_flag_reg;
   logic [31:0]            prdata_reg;
   logic                   lf_sync1_reg;
   logic                   lf_sync2_reg;
   logic                   lf_sync3_reg;

   logic                   lf_rise;
   logic                   addr_hit;
   logic                   wr_en;
   logic [31:0]            rd_mux;
   logic [31:0]            count_now;
   logic [31:0]            match_mask;
   logic [31:0]            period_mask;
   logic                   match_hit;
   logic                   period_hit;
   logic                   match_clr;
   logic                   period_clr;
   logic                   day_load;
   logic                   sub_load;
   logic                   tick_wrap;
   logic                   day_wrap;
   logic                   cal_paused;
   logic [CAL_WIDTH-1:0]   cal_inc;

   // The pin is asynchronous; the edge detector compares the second stage with the third.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         lf_sync1_reg <= 1'b0;
         lf_sync2_reg <= 1'b0;
         lf_sync3_reg <= 1'b0;
      end else begin
         lf_sync1_reg <= i_lowfreq_clock;
         lf_sync2_reg <= lf_sync1_reg;
         lf_sync3_reg <= lf_sync2_reg;
      end
   end

   assign lf_rise = lf_sync2_reg & ~lf_sync3_reg;

   always_comb begin
      case (i_paddr)
         `REG_ADDR(`IDX_LF_CFG),   `REG_ADDR(`IDX_HF_TUNE),
         `REG_ADDR(`IDX_CAL_CNT),  `REG_ADDR(`IDX_CAL_CTRL),
         `REG_ADDR(`IDX_PLL_CFG),  `REG_ADDR(`IDX_FLAG_CTRL),
         `REG_ADDR(`IDX_MODE_CTRL), `REG_ADDR(`IDX_TRIG),
         `REG_ADDR(`IDX_TICK_CNT), `REG_ADDR(`IDX_TWO_SEC_CNT),
         `REG_ADDR(`IDX_DAY_CNT): addr_hit = 1'b1;
         default: addr_hit = 1'b0;
      endcase
   end

   // Zero wait states; an unmapped address answers with an error and no effect.
   assign o_pready  = 1'b1;
   assign o_pslverr = i_psel & i_penable & ~addr_hit;
   assign wr_en     = i_psel & i_penable & i_pwrite & addr_hit;
   assign o_prdata  = prdata_reg;

   assign day_load   = wr_en && i_paddr == `REG_ADDR(`IDX_MODE_CTRL)
                       && i_pwdata[`MODE_DAY_LOAD_BIT];
   assign sub_load   = wr_en && i_paddr == `REG_ADDR(`IDX_MODE_CTRL)
                       && i_pwdata[`MODE_SUB_LOAD_BIT];
   assign match_clr  = wr_en && i_paddr == `REG_ADDR(`IDX_FLAG_CTRL)
                       && i_pwdata[`FLG_MATCH_CLR_BIT] && match_en_reg;
   assign period_clr = wr_en && i_paddr == `REG_ADDR(`IDX_FLAG_CTRL)
                       && i_pwdata[`FLG_PERIOD_CLR_BIT] && period_en_reg;
   assign cal_paused = (cal_state_reg == CAL_IDLE);

   always_comb begin
      rd_mux = 32'h0;
      case (i_paddr)
         `REG_ADDR(`IDX_LF_CFG): begin
            rd_mux[`LF_PIN_BIT]    = lf_sync2_reg;
            rd_mux[`LF_SRC_BIT]    = osc_reg.source_select;
            rd_mux[`LF_RC_PON_BIT] = osc_reg.rc_power;
            rd_mux[`LF_XT_PON_BIT] = osc_reg.crystal_power;
         end
         `REG_ADDR(`IDX_HF_TUNE):  rd_mux[7:0] = hf_tune_reg;
         `REG_ADDR(`IDX_CAL_CNT):  rd_mux[CAL_WIDTH-1:0] = cal_count_reg;
         `REG_ADDR(`IDX_CAL_CTRL): begin
            rd_mux[`CAL_HALT_BIT] = cal_paused;
            rd_mux[`CAL_EN_BIT]   = cal_en_reg;
         end
         `REG_ADDR(`IDX_PLL_CFG):  rd_mux[`PLL_MSB:0] = pll_reg;
         `REG_ADDR(`IDX_FLAG_CTRL): begin
            rd_mux[`FLG_MATCH_BIT]      = match_flag_reg;
            rd_mux[`FLG_PERIOD_BIT]     = period_flag_reg;
            rd_mux[`FLG_MATCH_CLR_BIT]  = ~match_en_reg;
            rd_mux[`FLG_PERIOD_CLR_BIT] = ~period_en_reg;
         end
         `REG_ADDR(`IDX_MODE_CTRL): begin
            rd_mux[`MODE_MATCH_EN_BIT]  = match_en_reg;
            rd_mux[`MODE_PERIOD_EN_BIT] = period_en_reg;
            rd_mux[`MODE_IGN_LSB_BIT]   = ignore_lsb_reg;
            rd_mux[`MODE_SEL_MSB:0]     = period_sel_reg;
         end
         `REG_ADDR(`IDX_TRIG):        rd_mux = trig_reg;
         `REG_ADDR(`IDX_TICK_CNT):    rd_mux[15:0] = tick_reg;
         `REG_ADDR(`IDX_TWO_SEC_CNT): rd_mux[15:0] = two_sec_reg;
         `REG_ADDR(`IDX_DAY_CNT):     rd_mux[`DAY_WIDTH-1:0] = day_reg;
         default: rd_mux = 32'h0;
      endcase
   end

   // Read data is captured in the setup phase so it stands through the access phase.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         prdata_reg <= 32'h0;
      end else if (i_psel && !i_penable && !i_pwrite) begin
         prdata_reg <= rd_mux;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         osc_reg     <= '{source_select: 1'b0, rc_power: 1'b1, crystal_power: 1'b0};
         hf_tune_reg <= `HF_TUNE_RST;
         pll_reg     <= `PLL_RST;
      end else if (wr_en) begin
         if (i_paddr == `REG_ADDR(`IDX_LF_CFG)) begin
            osc_reg.source_select <= i_pwdata[`LF_SRC_BIT];
            osc_reg.rc_power      <= i_pwdata[`LF_RC_PON_BIT];
            osc_reg.crystal_power <= i_pwdata[`LF_XT_PON_BIT];
         end
         if (i_paddr == `REG_ADDR(`IDX_HF_TUNE)) begin
            hf_tune_reg <= i_pwdata[7:0] & `HF_TUNE_MASK;
         end
         if (i_paddr == `REG_ADDR(`IDX_PLL_CFG)) begin
            pll_reg <= i_pwdata[`PLL_MSB:0];
         end
      end
   end

   assign o_osc_ctrl  = osc_reg;
   assign o_hf_tune   = hf_tune_reg;
   assign o_pll_param = pll_reg;

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         match_en_reg   <= 1'b0;
         period_en_reg  <= 1'b0;
         ignore_lsb_reg <= 1'b0;
         period_sel_reg <= `MODE_SEL_RST;
         trig_reg       <= 32'h0;
         cal_en_reg     <= 1'b0;
      end else if (wr_en) begin
         if (i_paddr == `REG_ADDR(`IDX_MODE_CTRL)) begin
            match_en_reg   <= i_pwdata[`MODE_MATCH_EN_BIT];
            period_en_reg  <= i_pwdata[`MODE_PERIOD_EN_BIT];
            ignore_lsb_reg <= i_pwdata[`MODE_IGN_LSB_BIT];
            period_sel_reg <= i_pwdata[`MODE_SEL_MSB:0];
         end
         if (i_paddr == `REG_ADDR(`IDX_TRIG)) begin
            trig_reg <= i_pwdata;
         end
         if (i_paddr == `REG_ADDR(`IDX_CAL_CTRL)) begin
            cal_en_reg <= i_pwdata[`CAL_EN_BIT];
         end
      end
   end

   // Calibration: a window opens on a slow rising edge and closes on the fifth after it.
   // At this system rate the true count exceeds the field, so it saturates at all ones.
   assign cal_inc = (&cal_cycles_reg) ? cal_cycles_reg : cal_cycles_reg + 1'b1;

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cal_state_reg  <= CAL_IDLE;
         cal_cycles_reg <= '0;
         cal_edges_reg  <= '0;
         cal_count_reg  <= '0;
      end else begin
         case (cal_state_reg)
            CAL_IDLE: begin
               if (cal_en_reg) begin
                  cal_state_reg <= CAL_ARM;
               end
            end
            CAL_ARM: begin
               if (!cal_en_reg) begin
                  cal_state_reg <= CAL_IDLE;
               end else if (lf_rise) begin
                  cal_state_reg  <= CAL_RUN;
                  cal_cycles_reg <= '0;
                  cal_edges_reg  <= '0;
               end
            end
            CAL_RUN: begin
               if (!cal_en_reg) begin
                  cal_state_reg <= CAL_IDLE;
               end else if (lf_rise && cal_edges_reg == EW'(CAL_PERIODS - 1)) begin
                  cal_count_reg  <= cal_inc;
                  cal_cycles_reg <= '0;
                  cal_edges_reg  <= '0;
               end else begin
                  cal_cycles_reg <= cal_inc;
                  if (lf_rise) begin
                     cal_edges_reg <= cal_edges_reg + 1'b1;
                  end
               end
            end
            default: cal_state_reg <= CAL_IDLE;
         endcase
      end
   end

   assign tick_wrap = lf_rise & (&tick_reg);
   assign day_wrap  = tick_wrap & (two_sec_reg == `TWO_SEC_PER_DAY - 16'h1);

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         tick_reg    <= 16'h0;
         two_sec_reg <= 16'h0;
      end else if (sub_load) begin
         two_sec_reg <= trig_reg[31:16];
         tick_reg    <= trig_reg[15:0];
      end else if (lf_rise) begin
         tick_reg <= tick_reg + 16'h1;
         if (tick_wrap) begin
            two_sec_reg <= day_wrap ? 16'h0 : two_sec_reg + 16'h1;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         day_reg <= '0;
      end else if (day_load) begin
         day_reg <= trig_reg[`DAY_WIDTH-1:0];
      end else if (day_wrap && !sub_load) begin
         day_reg <= day_reg + 1'b1;
      end
   end

   // Each counter value is compared once, on the tick that ends it; with the low bit ignored a match hits on two ticks in a row.
   assign count_now   = {two_sec_reg, tick_reg};
   assign match_mask  = ignore_lsb_reg ? 32'hffff_fffe : 32'hffff_ffff;
   assign period_mask = (`PERIOD_BASE_TICKS << period_sel_reg) - 32'h1;
   assign match_hit   = match_en_reg & lf_rise & (((count_now ^ trig_reg) & match_mask) == 32'h0);
   assign period_hit  = period_en_reg & lf_rise & ((count_now & period_mask) == 32'h0);

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         match_flag_reg  <= 1'b0;
         period_flag_reg <= 1'b0;
      end else begin
         if (match_hit) begin
            match_flag_reg <= 1'b1;
         end else if (match_clr) begin
            match_flag_reg <= 1'b0;
         end
         if (period_hit) begin
            period_flag_reg <= 1'b1;
         end else if (period_clr) begin
            period_flag_reg <= 1'b0;
         end
      end
   end

   assign o_match_flag  = match_flag_reg;
   assign o_period_flag = period_flag_reg;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   sequence s_cfg_write;
      wr_en && i_paddr == `REG_ADDR(`IDX_LF_CFG);
   endsequence

   sequence s_flag_read;
      i_psel && !i_penable && !i_pwrite && i_paddr == `REG_ADDR(`IDX_FLAG_CTRL);
   endsequence
   chk_source_select: assert property (s_cfg_write |=>
      o_osc_ctrl.source_select == $past(i_pwdata[`LF_SRC_BIT])) else $error("source select lost");
   chk_rc_power_write: assert property (s_cfg_write |=>
      o_osc_ctrl.rc_power == $past(i_pwdata[`LF_RC_PON_BIT])) else $error("rc power lost");
   chk_crystal_power_write: assert property (s_cfg_write |=>
      o_osc_ctrl.crystal_power == $past(i_pwdata[`LF_XT_PON_BIT])) else $error("crystal power");
   chk_cal_pause_status: assert property ($fell(cal_en_reg) |=>
      cal_paused ##1 cal_paused) else $error("calibration not paused after disable");
   chk_match_flag_set: assert property (match_hit |=>
      o_match_flag [*2] or (o_match_flag ##1 !o_match_flag)) else $error("match flag not set");
   chk_period_flag_set: assert property (period_hit |=> o_period_flag)
      else $error("period flag not set");
   chk_match_clear_idle: assert property (s_flag_read ##0 !match_en_reg |=>
      o_prdata[`FLG_MATCH_CLR_BIT]) else $error("clear bit not read as one");
   chk_period_clear_done: assert property (period_clr && !period_hit |=> !o_period_flag)
      else $error("period flag not cleared");
   chk_day_preload_value: assert property (day_load |=>
      day_reg == $past(trig_reg[`DAY_WIDTH-1:0])) else $error("day preload wrong");
   chk_sub_preload_value: assert property (sub_load |=> count_now == $past(trig_reg))
      else $error("sub-day preload wrong");
   chk_pll_reserved_zero: assert property (i_psel && !i_penable && !i_pwrite
      && i_paddr == `REG_ADDR(`IDX_PLL_CFG) |=> o_prdata[31:7] == 25'h0)
      else $error("pll reserved bits nonzero");

endmodule : rtc_lowfreq_clock_control

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
`include "rtc_lf_cfg.svh"

module tb_top;
   import rtc_lf_pkg::*;

   localparam logic [11:0] A_CFG  = 12'(`REG_ADDR(`IDX_LF_CFG));
   localparam logic [11:0] A_CNT  = 12'(`REG_ADDR(`IDX_CAL_CNT));
   localparam logic [11:0] A_CAL  = 12'(`REG_ADDR(`IDX_CAL_CTRL));
   localparam logic [11:0] A_PLL  = 12'(`REG_ADDR(`IDX_PLL_CFG));
   localparam logic [11:0] A_FLG  = 12'(`REG_ADDR(`IDX_FLAG_CTRL));
   localparam logic [11:0] A_MODE = 12'(`REG_ADDR(`IDX_MODE_CTRL));
   localparam logic [11:0] A_TRIG = 12'(`REG_ADDR(`IDX_TRIG));
   localparam logic [11:0] A_TICK = 12'(`REG_ADDR(`IDX_TICK_CNT));
   localparam logic [11:0] A_TWO  = 12'(`REG_ADDR(`IDX_TWO_SEC_CNT));
   localparam logic [11:0] A_DAY  = 12'(`REG_ADDR(`IDX_DAY_CNT));
   // Half a slow period is about 16 us, which is 4000 cycles at 4 ns.
   localparam int          SRC_WAIT = 4000;

   logic           i_clk, i_rstn, i_psel, i_penable, i_pwrite, i_lowfreq_clock;
   logic [11:0]    i_paddr;
   logic [31:0]    i_pwdata, o_prdata;
   logic           o_pready, o_pslverr, o_match_flag, o_period_flag;
   osc_ctrl_t      o_osc_ctrl;
   logic [7:0]     o_hf_tune;
   logic [6:0]     o_pll_param;
   int             err_total, comparisons;
   logic [31:0]    rd;
   logic           rerr;

   rtc_lowfreq_clock_control dut (
      .i_clk(i_clk), .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable),
      .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
      .o_pready(o_pready), .o_pslverr(o_pslverr), .i_lowfreq_clock(i_lowfreq_clock),
      .o_osc_ctrl(o_osc_ctrl), .o_hf_tune(o_hf_tune), .o_pll_param(o_pll_param),
      .o_match_flag(o_match_flag), .o_period_flag(o_period_flag));

   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end

   task automatic check32(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check32

   task automatic check1(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check1

   task automatic check_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
      comparisons++;
      if (!(got >= lo && got <= hi)) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask : check_rng

   // Holds the request until pready is seen high, then releases it.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_psel <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clk);
      i_penable <= 1'b1;
      do begin
         @(posedge i_clk);
      end while (o_pready !== 1'b1);
      rd = o_prdata;
      rerr = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask : apb

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check32(rd, exp);
   endtask : rd_chk

   // A slow edge is spaced well apart so the two-flop synchroniser sees it cleanly.
   task automatic slow_edge;
      i_lowfreq_clock <= 1'b1;
      repeat (8) @(posedge i_clk);
      i_lowfreq_clock <= 1'b0;
      repeat (8) @(posedge i_clk);
   endtask : slow_edge

   task automatic set_count(input logic [31:0] v, input logic [7:0] mode);
      apb(1'b1, A_TRIG, v);
      apb(1'b1, A_MODE, {24'h0, mode | 8'h40});
   endtask : set_count

   task automatic t_reset_values;
      rd_chk(A_CFG, 32'h0000_0002);
      check32({29'h0, o_osc_ctrl}, 32'h0000_0002);
      check32({24'h0, o_hf_tune}, 32'h0000_0031);
      rd_chk(A_CAL, 32'h0000_0002);
      rd_chk(A_PLL, 32'h0000_004a);
      rd_chk(A_FLG, 32'h0000_0030);
      rd_chk(A_MODE, 32'h0000_0002);
      check1(o_match_flag, 1'b0);
      check1(o_period_flag, 1'b0);
   endtask : t_reset_values

   task automatic t_osc_config;
      apb(1'b1, A_CFG, 32'h0000_0005);
      repeat (SRC_WAIT) @(posedge i_clk);
      check32({29'h0, o_osc_ctrl}, 32'h0000_0005);
      i_lowfreq_clock <= 1'b1;
      repeat (6) @(posedge i_clk);
      rd_chk(A_CFG, 32'h0000_0085);
      i_lowfreq_clock <= 1'b0;
      repeat (6) @(posedge i_clk);
      apb(1'b1, A_CFG, 32'hffff_ff7a);
      rd_chk(A_CFG, 32'h0000_0002);
      apb(1'b1, A_PLL, 32'hffff_ffff);
      rd_chk(A_PLL, 32'h0000_007f);
      check32({25'h0, o_pll_param}, 32'h0000_007f);
      apb(1'b0, 12'h004, 32'h0);
      check32({31'h0, rerr}, 32'h1);
      check32(rd, 32'h0);
   endtask : t_osc_config

   task automatic t_preload_carry;
      set_count(32'h0000_1234, 8'h82);
      rd_chk(A_DAY, 32'h0000_1234);
      set_count(32'ha8bf_ffff, 8'h02);
      rd_chk(A_TICK, 32'h0000_ffff);
      rd_chk(A_TWO, 32'h0000_a8bf);
      rd_chk(A_MODE, 32'h0000_0002);
      slow_edge();
      rd_chk(A_TICK, 32'h0000_0000);
      rd_chk(A_TWO, 32'h0000_0000);
      rd_chk(A_DAY, 32'h0000_1235);
   endtask : t_preload_carry

   task automatic t_match;
      set_count(32'h0000_0010, 8'h22);
      apb(1'b1, A_TRIG, 32'h0000_0011);
      slow_edge();
      check1(o_match_flag, 1'b0);
      slow_edge();
      check1(o_match_flag, 1'b1);
      rd_chk(A_FLG, 32'h0000_0090);
      apb(1'b1, A_FLG, 32'h0000_0020);
      rd_chk(A_FLG, 32'h0000_0010);
      check1(o_match_flag, 1'b0);
      set_count(32'h0000_0010, 8'h2a);
      apb(1'b1, A_TRIG, 32'h0000_0011);
      slow_edge();
      check1(o_match_flag, 1'b1);
      apb(1'b1, A_MODE, 32'h0000_0002);
      rd_chk(A_FLG, 32'h0000_00b0);
      apb(1'b1, A_FLG, 32'h0000_0020);
      @(posedge i_clk);
      check1(o_match_flag, 1'b1);
   endtask : t_match

   // Each period choice is hit on the slow edge after its low bits roll over to zero.
   task automatic t_period;
      logic [31:0] v;
      for (int s = 0; s < 8; s++) begin
         v = (32'h1 << (12 + s)) - 32'h1;
         set_count(v, 8'h10 | 8'(s));
         apb(1'b1, A_FLG, 32'h0000_0010);
         @(posedge i_clk);
         check1(o_period_flag, 1'b0);
         slow_edge();
         check1(o_period_flag, 1'b0);
         slow_edge();
         check1(o_period_flag, 1'b1);
      end
      rd_chk(A_FLG, 32'h0000_00e0);
      apb(1'b1, A_FLG, 32'h0000_0010);
      rd_chk(A_FLG, 32'h0000_00a0);
      apb(1'b1, A_MODE, 32'h0000_0002);
   endtask : t_period

   task automatic t_calibration;
      apb(1'b1, A_CAL, 32'h0000_0001);
      rd_chk(A_CAL, 32'h0000_0001);
      repeat (8) slow_edge();
      apb(1'b0, A_CNT, 32'h0);
      check_rng(rd, 32'd78, 32'd82);
      apb(1'b1, A_CAL, 32'h0000_0000);
      repeat (4) @(posedge i_clk);
      rd_chk(A_CAL, 32'h0000_0002);
   endtask : t_calibration

   task automatic final_report;
      $display("comparisons=%0d err_total=%0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : final_report

   initial begin
      repeat (20000) @(posedge i_clk);
      err_total++;
      final_report();
   end

   initial begin
      err_total = 0;
      comparisons = 0;
      i_rstn = 1'b0;
      i_psel = 1'b0;
      i_penable = 1'b0;
      i_pwrite = 1'b0;
      i_paddr = 12'h000;
      i_pwdata = 32'h0;
      i_lowfreq_clock = 1'b0;
      repeat (16) @(posedge i_clk);
      i_rstn <= 1'b1;
      t_reset_values();
      t_osc_config();
      t_preload_carry();
      t_match();
      t_period();
      t_calibration();
      final_report();
   end
endmodule : tb_top
